// ===== rtl/clock_routing_pkg.sv
package clock_routing_pkg;
  localparam int unsigned NUM_OUTPUTS    = 8;
  localparam int unsigned NUM_PLLS       = 2;
  localparam int unsigned RDIV_W         = 3;
  localparam int unsigned RDIV_CNT_W     = 7;
  localparam int unsigned PREDIV_W       = 2;
  localparam int unsigned PREDIV_CNT_W   = 2;
  localparam int unsigned LOAD_CAP_W     = 2;
  // output divider exponent range, divide by 2**n
  localparam logic [2:0]  RDIV_MIN       = 3'h1;
  localparam logic [2:0]  RDIV_MAX       = 3'h7;
  // reference source select
  localparam logic        SRC_EXT_REF    = 1'b0;
  localparam logic        SRC_CRYSTAL    = 1'b1;
  // pll select for each fractional divider
  localparam logic        SEL_FIRST_PLL  = 1'b0;
  localparam logic        SEL_SECOND_PLL = 1'b1;
  // crystal load capacitance codes
  localparam logic [1:0]  CAP_0PF        = 2'h0;
  localparam logic [1:0]  CAP_6PF        = 2'h1;
  localparam logic [1:0]  CAP_8PF        = 2'h2;
  localparam logic [1:0]  CAP_10PF       = 2'h3;
  localparam logic [1:0]  CAP_RESET      = 2'h0;
  // frequency limits, in kHz
  localparam int unsigned EXT_REF_MIN_KHZ  = 10000;
  localparam int unsigned EXT_REF_MAX_KHZ  = 100000;
  localparam int unsigned PLL_IN_MAX_KHZ   = 30000;
  localparam int unsigned HIGH_FREQ_KHZ    = 112500;
  localparam real         OUT_MIN_KHZ      = 2.5;
  // disabled-state encoding
  typedef enum logic [1:0] {
    STOP_LOW  = 2'h0,
    STOP_HIGH = 2'h1,
    STOP_HIZ  = 2'h2
  } stop_state_e;
  localparam logic [1:0]  STOP_RESET     = 2'h0;
  localparam logic        INV_RESET      = 1'b0;
  localparam logic        EN_RESET       = 1'b0;
  localparam logic [2:0]  RDIV_RESET     = 3'h1;
endpackage : clock_routing_pkg

// ===== rtl/gate_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gate_ctrl_if;
  logic       src_clk;
  logic       out_on;
  logic       spread_ok;
  logic [2:0] rdiv_n;
  logic       invert;
  logic [1:0] stop_state;
  logic       level;
  logic       oe;
  logic       spread_act;
  modport top  (output src_clk, out_on, spread_ok, rdiv_n, invert, stop_state,
                input level, oe, spread_act);
  modport gate (input src_clk, out_on, spread_ok, rdiv_n, invert, stop_state,
                output level, oe, spread_act);
endinterface : gate_ctrl_if
`default_nettype wire

// ===== rtl/ref_prediv.sv
`timescale 1ns/1ps
`default_nettype none
// divides the external reference by 1, 2, 3 or 4 (div_sel + 1)
module ref_prediv (
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  ref_tick,
  input  wire logic [clock_routing_pkg::PREDIV_W-1:0] div_sel,
  output logic                                       div_tick
);
  logic [clock_routing_pkg::PREDIV_CNT_W-1:0] cnt_ff;
  logic [clock_routing_pkg::PREDIV_CNT_W-1:0] nxt_cnt;
  logic                                       tick_ff;
  logic                                       nxt_tick;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (ref_tick) begin
      if (cnt_ff >= div_sel) begin
        nxt_cnt  = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign div_tick = tick_ff;
endmodule : ref_prediv
`default_nettype wire

// ===== rtl/out_gate.sv
`timescale 1ns/1ps
`default_nettype none
// one output: integer 2**n divider plus glitchless enable gating
module out_gate (
  input  wire logic clk,
  input  wire logic rst,
  gate_ctrl_if.gate g
);
  logic [clock_routing_pkg::RDIV_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic                                     run_ff, nxt_run;
  logic                                     lvl_ff, nxt_lvl;
  logic                                     oe_ff, nxt_oe;
  logic                                     src_d_ff;
  logic                                     sp_ff, nxt_sp;
  logic                                     src_rise;
  logic [2:0]                               n_eff;
  logic                                     wave;
  logic                                     lead;
  logic                                     period_end;

  always_comb begin
    // [R14] exponent clamped 1..7
    n_eff = g.rdiv_n;
    if (n_eff < clock_routing_pkg::RDIV_MIN) n_eff = clock_routing_pkg::RDIV_MIN;
    src_rise   = g.src_clk & ~src_d_ff;
    // high in the first half, so a wrap is a rising edge
    wave       = ~cnt_ff[n_eff - 3'h1];
    // leading edge: counter wraps to zero, wave goes high
    lead       = src_rise && ((cnt_ff | ~((7'h1 << n_eff) - 7'h1)) == 7'h7f);
    period_end = lead;
    nxt_cnt    = src_rise ? cnt_ff + 7'h1 : cnt_ff;
    if (src_rise && lead) nxt_cnt = '0;
    nxt_run = run_ff;
    // [R3] start on leading edge
    if (!run_ff && g.out_on && lead) nxt_run = 1'b1;
    // [R4] finish full period
    if (run_ff && !g.out_on && period_end) nxt_run = 1'b0;
    nxt_lvl = lvl_ff;
    nxt_oe  = 1'b1;
    if (nxt_run) begin
      nxt_lvl = (lead ? 1'b1 : wave) ^ g.invert;
    end else begin
      // [R2] configured stop state
      case (g.stop_state)
        clock_routing_pkg::STOP_HIGH: nxt_lvl = 1'b1;
        clock_routing_pkg::STOP_HIZ: begin
          nxt_lvl = 1'b0;
          nxt_oe  = 1'b0;
        end
        default: nxt_lvl = 1'b0;
      endcase
    end
    nxt_sp = g.spread_ok & nxt_run;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff   <= '0;
      run_ff   <= 1'b0;
      lvl_ff   <= 1'b0;
      oe_ff    <= 1'b1;
      src_d_ff <= 1'b0;
      sp_ff    <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      run_ff   <= nxt_run;
      lvl_ff   <= nxt_lvl;
      oe_ff    <= nxt_oe;
      src_d_ff <= g.src_clk;
      sp_ff    <= nxt_sp;
    end
  end

  assign g.level      = lvl_ff;
  assign g.oe         = oe_ff;
  assign g.spread_act = sp_ff;
endmodule : out_gate
`default_nettype wire

// ===== rtl/clock_routing_output_gating.sv
// Notes on behaviour
// [R1] outputs enabled while outputs_off_pin low, disabled while high
// [R2] disabled output goes high, low or high impedance as configured
// [R3] enabled output starts only at first leading edge after pin falls
// [R4] on disable the current full output period completes first
// [R5] spread_gate_pin low suppresses spread on all spread-enabled outputs
// [R6] spread allowed only on outputs fed by the first pll
// [R7] each pll picks external reference or crystal independently
// [R8] each fractional divider picks first or second pll independently
// [R9] tuned path comes from second pll only, may feed many dividers
// [R10] software keeps at most two distinct frequencies above 112.5 MHz
// [R11] external reference 10 to 100 MHz, prescaled to at most 30 MHz
// [R12] integer output divider after each fractional divider, down to 2.5 kHz
// [R13] crystal load capacitance selects 0, 6, 8 or 10 pF
// [R14] output divider is two to the n, n from 1 to 7
// [R15] each output has its own enable and invert settings
// [R16] pin levels pass two flip-flops before gating acts on them
`timescale 1ns/1ps
`default_nettype none
module clock_routing_output_gating (
  input  wire logic                                          clk,
  input  wire logic                                          rst,
  input  wire logic                                          outputs_off_pin_n,
  input  wire logic                                          spread_gate_pin,
  input  wire logic                                          crystal_reference,
  input  wire logic                                          external_ref_input,
  input  wire logic                                          first_pll_clk,
  input  wire logic                                          second_pll_clk,
  input  wire logic                                          tune_voltage_input,
  input  wire logic [clock_routing_pkg::NUM_PLLS-1:0]        pll_ref_sel,
  input  wire logic [clock_routing_pkg::PREDIV_W-1:0]        ext_prediv_sel,
  input  wire logic [clock_routing_pkg::LOAD_CAP_W-1:0]      load_cap_sel,
  input  wire logic                                          tuned_mode,
  input  wire logic [clock_routing_pkg::NUM_OUTPUTS-1:0]     div_pll_sel,
  input  wire logic [clock_routing_pkg::NUM_OUTPUTS-1:0]     out_enable,
  input  wire logic [clock_routing_pkg::NUM_OUTPUTS-1:0]     out_invert,
  input  wire logic [clock_routing_pkg::NUM_OUTPUTS-1:0]     spread_enable,
  input  wire logic [clock_routing_pkg::NUM_OUTPUTS*3-1:0]   rdiv_exp,
  input  wire logic [clock_routing_pkg::NUM_OUTPUTS*2-1:0]   stop_state,
  output logic [clock_routing_pkg::NUM_PLLS-1:0]             pll_ref_out,
  output logic                                               ext_ref_div_tick,
  output logic [clock_routing_pkg::LOAD_CAP_W-1:0]           load_cap_out,
  output logic                                               tune_active,
  output logic [clock_routing_pkg::NUM_OUTPUTS-1:0]          div_src_clk,
  output logic [clock_routing_pkg::NUM_OUTPUTS-1:0]          clock_output,
  output logic [clock_routing_pkg::NUM_OUTPUTS-1:0]          clock_output_oe,
  output logic [clock_routing_pkg::NUM_OUTPUTS-1:0]          spread_active
);
  localparam int unsigned N = clock_routing_pkg::NUM_OUTPUTS;

  // two-stage synchronisers for pins and async clocks
  logic [6:0] s1_ff;
  logic [6:0] s2_ff;
  logic [6:0] nxt_s1;
  logic       tune_s;
  logic       off_n_s;
  logic       sgate_s;
  logic       crystal_reference_s;
  logic       ext_s;
  logic       pa_s;
  logic       pb_s;
  logic       ext_d_ff;
  logic       nxt_ext_d;
  logic       ext_rise;
  logic       prediv_tick;

  always_comb begin
    nxt_s1 = {tune_voltage_input, outputs_off_pin_n, spread_gate_pin, crystal_reference,
              external_ref_input, first_pll_clk, second_pll_clk};
    nxt_ext_d = ext_s;
  end

  // [R16] two-flop synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff    <= 7'h3f;
      s2_ff    <= 7'h3f;
      // same as synced reset level, no false edge
      ext_d_ff <= 1'b1;
    end else begin
      s1_ff    <= nxt_s1;
      s2_ff    <= s1_ff;
      ext_d_ff <= nxt_ext_d;
    end
  end

  assign tune_s   = s2_ff[6];
  assign off_n_s  = s2_ff[5];
  assign sgate_s  = s2_ff[4];
  assign crystal_reference_s   = s2_ff[3];
  assign ext_s    = s2_ff[2];
  assign pa_s     = s2_ff[1];
  assign pb_s     = s2_ff[0];
  assign ext_rise = ext_s & ~ext_d_ff;

  // [R11] external reference prescaler
  ref_prediv u_prediv (
    .clk      (clk),
    .rst      (rst),
    .ref_tick (ext_rise),
    .div_sel  (ext_prediv_sel),
    .div_tick (prediv_tick)
  );

  // first stage crosspoint and config registers
  logic [clock_routing_pkg::NUM_PLLS-1:0]   ref_ff, nxt_ref;
  logic [clock_routing_pkg::LOAD_CAP_W-1:0] cap_ff, nxt_cap;
  logic                                     tick_ff, nxt_tick;
  logic                                     tune_ff, nxt_tune;
  logic [N-1:0]                             dsrc_ff, nxt_dsrc;
  logic [N-1:0]                             sel_eff;

  always_comb begin
    for (int p = 0; p < clock_routing_pkg::NUM_PLLS; p++) begin
      // [R7] per-pll reference select
      nxt_ref[p] = (pll_ref_sel[p] == clock_routing_pkg::SRC_CRYSTAL) ? crystal_reference_s : ext_s;
    end
    // [R13] load capacitance setting
    nxt_cap  = load_cap_sel;
    nxt_tick = prediv_tick;
    nxt_tune = tuned_mode & tune_s;
    for (int i = 0; i < N; i++) begin
      // [R9] tuned path forces second pll
      sel_eff[i] = tuned_mode ? clock_routing_pkg::SEL_SECOND_PLL : div_pll_sel[i];
      // [R8] per-divider pll select
      nxt_dsrc[i] = (sel_eff[i] == clock_routing_pkg::SEL_SECOND_PLL) ? pb_s : pa_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_ff  <= '0;
      cap_ff  <= clock_routing_pkg::CAP_RESET;
      tick_ff <= 1'b0;
      tune_ff <= 1'b0;
      dsrc_ff <= '0;
    end else begin
      ref_ff  <= nxt_ref;
      cap_ff  <= nxt_cap;
      tick_ff <= nxt_tick;
      tune_ff <= nxt_tune;
      dsrc_ff <= nxt_dsrc;
    end
  end

  assign pll_ref_out      = ref_ff;
  assign load_cap_out     = cap_ff;
  assign ext_ref_div_tick = tick_ff;
  assign tune_active      = tune_ff;
  assign div_src_clk      = dsrc_ff;

  // per-output gating
  logic [N-1:0] lvl_w;
  logic [N-1:0] oe_w;
  logic [N-1:0] sp_w;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_out
      gate_ctrl_if gc ();
      assign gc.src_clk    = dsrc_ff[gi];
      // [R1] [R15] shared pin and own enable
      assign gc.out_on     = ~off_n_s & out_enable[gi];
      // [R5] [R6] spread gating
      assign gc.spread_ok  = spread_enable[gi] & sgate_s & ~tuned_mode &
                             (sel_eff[gi] == clock_routing_pkg::SEL_FIRST_PLL);
      // [R12] [R14] output divider exponent
      assign gc.rdiv_n     = rdiv_exp[gi*3 +: 3];
      assign gc.invert     = out_invert[gi];
      assign gc.stop_state = stop_state[gi*2 +: 2];
      out_gate u_gate (
        .clk (clk),
        .rst (rst),
        .g   (gc)
      );
      assign lvl_w[gi] = gc.level;
      assign oe_w[gi]  = gc.oe;
      assign sp_w[gi]  = gc.spread_act;
    end
  endgenerate

  assign clock_output    = lvl_w;
  assign clock_output_oe = oe_w;
  assign spread_active   = sp_w;
endmodule : clock_routing_output_gating
`default_nettype wire

// ===== tb/clock_routing_chk.sv
`timescale 1ns/1ps
`default_nettype none
module clock_routing_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        spread_gate_pin,
  input wire logic        crystal_reference,
  input wire logic        external_ref_input,
  input wire logic        first_pll_clk,
  input wire logic        second_pll_clk,
  input wire logic [1:0]  pll_ref_sel,
  input wire logic [1:0]  load_cap_sel,
  input wire logic        tuned_mode,
  input wire logic [7:0]  div_pll_sel,
  input wire logic [7:0]  out_invert,
  input wire logic [7:0]  spread_enable,
  input wire logic [15:0] stop_state,
  input wire logic [1:0]  pll_ref_out,
  input wire logic        ext_ref_div_tick,
  input wire logic [1:0]  load_cap_out,
  input wire logic [7:0]  div_src_clk,
  input wire logic [7:0]  clock_output,
  input wire logic [7:0]  clock_output_oe,
  input wire logic [7:0]  spread_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [7:0] blk;
  logic [7:0] hiz;
  always_comb begin
    blk = div_pll_sel | {8{tuned_mode}};
    for (int k = 0; k < 8; k++) hiz[k] = (stop_state[2*k+:2] == 2'h2);
  end
  sequence refs_still;
    $stable({crystal_reference, external_ref_input, pll_ref_sel}) [*4];
  endsequence
  sequence plls_still;
    $stable({first_pll_clk, second_pll_clk, blk}) [*4];
  endsequence
  sequence cap_still;
    $stable(load_cap_sel) [*2];
  endsequence
  a_ref_cross: assert property (refs_still |-> pll_ref_out ==
    {pll_ref_sel[1] ? crystal_reference : external_ref_input,
     pll_ref_sel[0] ? crystal_reference : external_ref_input})
    else $error("pll reference routing wrong");
  a_div_cross: assert property (plls_still |-> div_src_clk ==
    ((blk & {8{second_pll_clk}}) | (~blk & {8{first_pll_clk}})))
    else $error("divider source routing wrong");
  a_spread_pll2: assert property ((spread_active & blk & $past(blk)) == 8'h00)
    else $error("spread active for second pll output");
  a_spread_gate: assert property ((!spread_gate_pin) [*4] |-> spread_active == 8'h00)
    else $error("spread active while gated off");
  a_spread_enable: assert property
    ((spread_active & ~spread_enable & ~$past(spread_enable)) == 8'h00)
    else $error("spread active without enable");
  a_hiz_only: assert property ((~clock_output_oe & ~hiz & ~$past(hiz)) == 8'h00)
    else $error("output released without hi-z stop code");
  a_start_high: assert property ($rose(clock_output_oe[2]) |->
    clock_output[2] != out_invert[2])
    else $error("output restarted mid period");
  a_cap_out: assert property (cap_still |-> load_cap_out == load_cap_sel)
    else $error("load cap code wrong");
  a_tick_single: assert property (ext_ref_div_tick |=> !ext_ref_div_tick)
    else $error("prescaler tick longer than one cycle");
endmodule : clock_routing_chk
bind clock_routing_output_gating clock_routing_chk u_chk (
  .clk(clk), .rst(rst), .spread_gate_pin(spread_gate_pin),
  .crystal_reference(crystal_reference), .external_ref_input(external_ref_input),
  .first_pll_clk(first_pll_clk), .second_pll_clk(second_pll_clk),
  .pll_ref_sel(pll_ref_sel), .load_cap_sel(load_cap_sel), .tuned_mode(tuned_mode),
  .div_pll_sel(div_pll_sel), .out_invert(out_invert), .spread_enable(spread_enable),
  .stop_state(stop_state), .pll_ref_out(pll_ref_out), .ext_ref_div_tick(ext_ref_div_tick),
  .load_cap_out(load_cap_out), .div_src_clk(div_src_clk), .clock_output(clock_output),
  .clock_output_oe(clock_output_oe), .spread_active(spread_active)
);
`default_nettype wire

// ===== tb/ref_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// free running references and plls, half periods in clk cycles
module ref_src_model #(
  parameter int HALF [4] = '{13, 6, 8, 11}
) (
  input  wire logic       clk,
  input  wire logic       rst,
  output logic      [3:0] lv
);
  int cnt [4] = '{0, 0, 0, 0};
  initial lv = 4'h0;
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] = (cnt[i] + 1) % HALF[i];
      if (cnt[i] == 0) lv[i] <= ~lv[i];
    end
  end
endmodule : ref_src_model
`default_nettype wire

// ===== tb/clock_routing_output_gating_bench.sv
`timescale 1ns/1ps
`default_nettype none
module clock_routing_output_gating_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        outputs_off_pin_n = 1'b1;
  logic        spread_gate_pin = 1'b1;
  logic        tune_voltage_input = 1'b0;
  logic        tuned_mode = 1'b0;
  logic [1:0]  pll_ref_sel = 2'h0;
  logic [1:0]  ext_prediv_sel = 2'h0;
  logic [1:0]  load_cap_sel = 2'h0;
  logic [7:0]  div_pll_sel = 8'h00;
  logic [7:0]  out_enable = 8'hff;
  logic [7:0]  out_invert = 8'h00;
  logic [7:0]  spread_enable = 8'h00;
  logic [23:0] rdiv_exp = 24'h0;
  logic [15:0] stop_state = 16'h0;
  logic [3:0]  lv;
  logic [1:0]  pll_ref_out;
  logic        ext_ref_div_tick;
  logic [1:0]  load_cap_out;
  logic        tune_active;
  logic [7:0]  div_src_clk;
  logic [7:0]  clock_output;
  logic [7:0]  clock_output_oe;
  logic [7:0]  spread_active;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          mon_last = -1;
  int          mon_idx = 0;
  logic        mon_tick = 1'b0;
  logic        mon_prev = 1'b0;
  logic        mon_now;
  logic [31:0] exp_q [$];
  logic [31:0] seed = 32'h0084;
  ref_src_model u_refs (.clk, .rst, .lv);
  clock_routing_output_gating u_dut (
    .clk, .rst, .outputs_off_pin_n, .spread_gate_pin, .crystal_reference(lv[0]),
    .external_ref_input(lv[1]), .first_pll_clk(lv[2]), .second_pll_clk(lv[3]),
    .tune_voltage_input, .pll_ref_sel, .ext_prediv_sel, .load_cap_sel, .tuned_mode,
    .div_pll_sel, .out_enable, .out_invert, .spread_enable, .rdiv_exp, .stop_state,
    .pll_ref_out, .ext_ref_div_tick, .load_cap_out, .tune_active, .div_src_clk,
    .clock_output, .clock_output_oe, .spread_active);
  always #2 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic check_bits(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_bits
  task automatic check_period(input logic [31:0] got, input logic [31:0] exp);
    check_bits(got, exp);
  endtask : check_period
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // note an interval, then wait for the watcher to take it
  task automatic measure(input logic tick, input int idx, input logic [31:0] per);
    mon_tick = tick;
    mon_idx = idx;
    mon_last = -1;
    // no false edge when switching the watched signal
    mon_prev = 1'b1;
    exp_q.push_back(per);
    while (exp_q.size() != 0) @(posedge clk);
    #1;
  endtask : measure
  always @(posedge clk) begin
    cyc++;
    mon_now = mon_tick ? ext_ref_div_tick : clock_output[mon_idx];
    if (mon_now && !mon_prev && exp_q.size() != 0) begin
      if (mon_last >= 0) check_period(cyc - mon_last, exp_q.pop_front());
      mon_last = cyc;
    end
    mon_prev = mon_now;
    if (cyc > 30000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    step(3);
    rst = 1'b0;
    outputs_off_pin_n = 1'b0;
    for (int i = 0; i < 8; i++) begin
      repeat (8) seed = lfsr(seed);
      div_pll_sel = seed[7:0];
      spread_enable = seed[15:8];
      pll_ref_sel = seed[17:16];
      tuned_mode = seed[18];
      tune_voltage_input = seed[19];
      spread_gate_pin = seed[20];
      load_cap_sel = i[1:0];
      step(80);
      check_bits(spread_active, spread_enable & ~div_pll_sel &
        ~{8{tuned_mode}} & {8{spread_gate_pin}});
      check_bits(load_cap_out, load_cap_sel);
      check_bits(tune_active, tuned_mode & tune_voltage_input);
    end
    tuned_mode = 1'b0;
    div_pll_sel = 8'h00;
    rdiv_exp = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    step(20);
    for (int k = 0; k < 8; k++) measure(1'b0, k, (32'h1 << (k == 0 ? 1 : k)) * 16);
    for (int s = 0; s < 4; s++) begin
      ext_prediv_sel = s[1:0];
      step(40);
      measure(1'b1, 0, (s + 1) * 12);
    end
    stop_state = 16'he4e4;
    outputs_off_pin_n = 1'b1;
    step(2500);
    check_bits(clock_output_oe, 8'hbb);
    check_bits(clock_output & 8'hbb, 8'h22);
    out_enable = 8'hfe;
    outputs_off_pin_n = 1'b0;
    step(2500);
    check_bits(clock_output_oe, 8'hff);
    check_bits(clock_output[0], 1'b0);
    measure(1'b0, 3, 32'd128);
    check_bits(clock_output[3], 1'b1);
    out_invert = 8'h08;
    step(1);
    check_bits(clock_output[3], 1'b0);
    give_verdict();
  end
endmodule : clock_routing_output_gating_bench
`default_nettype wire
